// ==== include/sapt_pkg.sv ====
// Package with register map, control field positions and encodings of the timer block.
package sapt_pkg;
  localparam int          NUM_TIMERS   = 5;
  localparam int          CNT_W        = 16;
  // Timer slots: standalone, pair A even/odd, pair B even/odd.
  localparam int          T_SOLO       = 0;
  localparam int          T_A_EVEN     = 1;
  localparam int          T_A_ODD      = 2;
  localparam int          T_B_EVEN     = 3;
  localparam int          T_B_ODD      = 4;
  // Byte address: bit 7 zero, bits 6:4 timer slot, bits 3:2 register in the slot.
  localparam int          ADDR_W       = 8;
  localparam int          SLOT_HI      = 6;
  localparam int          SLOT_LO      = 4;
  localparam logic [1:0]  REG_CTRL     = 2'h0;
  localparam logic [1:0]  REG_COUNT    = 2'h1;
  localparam logic [1:0]  REG_PERIOD   = 2'h2;
  localparam logic [1:0]  REG_IRQ      = 2'h3;
  // Control register fields.
  localparam int          BIT_RUN      = 15;
  localparam int          BIT_IDLE     = 13;
  localparam int          BIT_GATE     = 6;
  localparam int          BIT_PS_HI    = 5;
  localparam int          BIT_PS_LO    = 4;
  localparam int          BIT_WIDE     = 3;
  localparam int          BIT_SYNC     = 2;
  localparam int          BIT_CS       = 1;
  localparam logic [15:0] MASK_SOLO    = 16'ha076;
  localparam logic [15:0] MASK_EVEN    = 16'ha07a;
  localparam logic [15:0] MASK_ODD     = 16'ha072;
  localparam logic [15:0] CTRL_RST     = 16'h0000;
  localparam logic [15:0] COUNT_RST    = 16'h0000;
  localparam logic [15:0] PERIOD_RST   = 16'hffff;
  localparam logic [15:0] COUNT_MAX    = 16'hffff;
  // Interrupt register fields.
  localparam int          IRQ_FLAG     = 0;
  localparam int          IRQ_EN       = 1;
  localparam int          IRQ_PRIO_LO  = 4;
  localparam int          PRIO_W       = 3;
  // Prescaler terminal counts for the four ratios.
  localparam int          PRE_W        = 8;
  localparam logic [7:0]  PRE_LAST_1   = 8'h00;
  localparam logic [7:0]  PRE_LAST_8   = 8'h07;
  localparam logic [7:0]  PRE_LAST_64  = 8'h3f;
  localparam logic [7:0]  PRE_LAST_256 = 8'hff;
  localparam logic [1:0]  PS_1         = 2'h0;
  localparam logic [1:0]  PS_8         = 2'h1;
  localparam logic [1:0]  PS_64        = 2'h2;
endpackage : sapt_pkg

// ==== logic/sapt_top.sv ====
// Standalone 16-bit timer and two pairs of 16-bit timers, each pair also one 32-bit timer, behind an Avalon-MM slave.
//
// How it works
// - Standalone timer is 16 bits: timer or synchronous counter; external edges always pass the synchroniser.
// - Standalone interrupt on period match or gate falling edge.
// - Control bit 15 starts counting when set, stops when clear.
// - Control bit 13 halts the timer while the device idles.
// - Bit 6 enables gated accumulation, only with the internal clock.
// - Bits 5-4 select prescale 1:1, 1:8, 1:64 or 1:256.
// - Bit 2 is writable on the standalone timer only and drives no logic; the external clock is always synchronised.
// - Bit 1 selects external rising edges or the internal clock.
// - Control bits 14, 12-7 and 0 are unwritable and read zero; so are bit 3 except on even timers and bit 2 except on the standalone.
// - Control write while running clears the prescale counter.
// - Standalone timer has period register, interrupt enable, three-bit priority.
// - Each pair works as one 32-bit timer or two 16-bit timers.
// - Paired timers count synchronously only, no asynchronous counter.
// - Converter trigger comes only from pair A odd timer or pair A 32-bit.
// - In 32-bit mode even control governs; odd flag reports the interrupt.
// - Even control bit 3 selects 32-bit pairing.
// - In 32-bit mode odd period is upper word, even period lower.
// - In 32-bit mode odd count is upper word, even count lower.
// - 32-bit pair interrupts when full count matches full period.
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module sapt_top #(
  parameter int NUM_TIMERS = sapt_pkg::NUM_TIMERS
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        idle_mode,
  input  wire logic        standalone_ext_clock_pin,
  input  wire logic [3:0]  pair_ext_clock_pin,
  output logic      [4:0]  irq_req,
  output logic      [14:0] irq_priority,
  output logic             adc_trigger
);

  if (NUM_TIMERS != sapt_pkg::NUM_TIMERS) begin : g_bad_count
    $error("sapt_top serves exactly five timers");
  end

  function automatic logic [15:0] ctrl_mask(input int idx);
    if (idx == sapt_pkg::T_SOLO) return sapt_pkg::MASK_SOLO;
    if (idx == sapt_pkg::T_A_EVEN || idx == sapt_pkg::T_B_EVEN) return sapt_pkg::MASK_EVEN;
    return sapt_pkg::MASK_ODD;
  endfunction : ctrl_mask

  function automatic logic [7:0] pre_last(input logic [1:0] ps);
    case (ps)
      sapt_pkg::PS_1:  pre_last = sapt_pkg::PRE_LAST_1;
      sapt_pkg::PS_8:  pre_last = sapt_pkg::PRE_LAST_8;
      sapt_pkg::PS_64: pre_last = sapt_pkg::PRE_LAST_64;
      default:         pre_last = sapt_pkg::PRE_LAST_256;
    endcase
  endfunction : pre_last

  function automatic logic [15:0] be_merge(input logic [15:0] old_v, input logic [31:0] wd,
                                           input logic [3:0] be);
    be_merge = old_v;
    if (be[0]) be_merge[7:0] = wd[7:0];
    if (be[1]) be_merge[15:8] = wd[15:8];
  endfunction : be_merge

  logic [15:0] ctrl_ff   [5];
  logic [15:0] count_ff  [5];
  logic [15:0] period_ff [5];
  logic [7:0]  pre_ff    [5];
  logic [2:0]  prio_ff   [5];
  logic [4:0]  flag_ff;
  logic [4:0]  ien_ff;
  logic [4:0]  irq_req_ff;
  logic        adc_trigger_ff;
  logic        waitreq_ff;
  logic [31:0] readdata_ff;
  logic [4:0]  pin_s1_ff;
  logic [4:0]  pin_s2_ff;
  logic [4:0]  pin_s3_ff;

  logic [4:0]  pins;
  logic [4:0]  running;
  logic [4:0]  evt;
  logic [4:0]  tick_w;
  logic [4:0]  use_tick;
  logic [4:0]  wide;
  logic [4:0]  set_match;
  logic [4:0]  gfall;
  logic [4:0]  set_flag;
  logic [4:0]  wr_slot;
  logic [1:0]  match32;
  logic [1:0]  carry32;
  logic [2:0]  slot;
  logic [1:0]  reg_sel;
  logic        hit;
  logic        req;
  logic        bus_wr;
  logic [31:0] nxt_readdata;

  assign pins    = {pair_ext_clock_pin, standalone_ext_clock_pin};
  assign slot    = avs_address[sapt_pkg::SLOT_HI:sapt_pkg::SLOT_LO];
  assign reg_sel = avs_address[3:2];
  assign hit     = !avs_address[7] && (slot < 3'h5) && (avs_address[1:0] == 2'h0);
  assign req     = avs_read || avs_write;
  assign bus_wr  = avs_write && !waitreq_ff && hit;

  // Pins come from outside the clock domain; stage three only feeds edge detection.
  // External clock synchroniser
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1_ff <= 5'h00;
      pin_s2_ff <= 5'h00;
      pin_s3_ff <= 5'h00;
    end else begin
      pin_s1_ff <= pins;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // Each request is answered one cycle after it is seen; waitrequest release and read data land together, a write takes effect one edge later.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      waitreq_ff  <= 1'b1;
      readdata_ff <= 32'h0000_0000;
    end else begin
      waitreq_ff <= !(req && waitreq_ff);
      if (avs_read && waitreq_ff) readdata_ff <= nxt_readdata;
    end
  end

  always_comb begin
    nxt_readdata = 32'h0000_0000;
    if (hit) begin
      case (reg_sel)
        sapt_pkg::REG_CTRL:   nxt_readdata[15:0] = ctrl_ff[slot];
        sapt_pkg::REG_COUNT:  nxt_readdata[15:0] = count_ff[slot];
        sapt_pkg::REG_PERIOD: nxt_readdata[15:0] = period_ff[slot];
        default: begin
          nxt_readdata[sapt_pkg::IRQ_FLAG] = flag_ff[slot];
          nxt_readdata[sapt_pkg::IRQ_EN]   = ien_ff[slot];
          nxt_readdata[sapt_pkg::IRQ_PRIO_LO +: sapt_pkg::PRIO_W] = prio_ff[slot];
        end
      endcase
    end
  end

  // 32-bit compare and low-word carry for each pair.
  for (genvar p = 0; p < 2; p++) begin : g_pair
    localparam int EV = 2 * p + 1;
    assign match32[p] = ({count_ff[EV+1], count_ff[EV]} == {period_ff[EV+1], period_ff[EV]});
    assign carry32[p] = (count_ff[EV] == sapt_pkg::COUNT_MAX);
  end

  for (genvar i = 0; i < 5; i++) begin : g_tmr
    localparam bit IS_ODD = (i == sapt_pkg::T_A_ODD) || (i == sapt_pkg::T_B_ODD);
    localparam int EV     = IS_ODD ? i - 1 : i;
    localparam int PI     = (i == 0) ? 0 : (i - 1) / 2;
    logic [1:0] ps;

    assign wr_slot[i] = bus_wr && (slot == 3'(i));
    assign ps         = ctrl_ff[i][sapt_pkg::BIT_PS_HI:sapt_pkg::BIT_PS_LO];
    // Pairing bit lives in the even control
    assign wide[i]    = (i != sapt_pkg::T_SOLO) && ctrl_ff[EV][sapt_pkg::BIT_WIDE];
    assign running[i] = ctrl_ff[i][sapt_pkg::BIT_RUN] &&
                        !(idle_mode && ctrl_ff[i][sapt_pkg::BIT_IDLE]);
    // Count source, gate only on internal clock
    assign evt[i] = running[i] && (ctrl_ff[i][sapt_pkg::BIT_CS] ?
                    (pin_s2_ff[i] && !pin_s3_ff[i]) :
                    (!ctrl_ff[i][sapt_pkg::BIT_GATE] || pin_s2_ff[i]));
    assign tick_w[i] = evt[i] && (pre_ff[i] >= pre_last(ps));
    // Odd half of a wide pair follows the even timer
    assign use_tick[i] = (IS_ODD && wide[i]) ? tick_w[EV] : tick_w[i];
    assign gfall[i] = running[i] && ctrl_ff[i][sapt_pkg::BIT_GATE] &&
                      !ctrl_ff[i][sapt_pkg::BIT_CS] && !pin_s2_ff[i] && pin_s3_ff[i];
    // Match events; the even half is silent when wide
    assign set_match[i] = use_tick[i] && (wide[i] ? (IS_ODD && match32[PI]) :
                                           (count_ff[i] == period_ff[i]));
    assign set_flag[i] = set_match[i] || (wide[i] ? (IS_ODD && gfall[EV]) : gfall[i]);

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        ctrl_ff[i] <= sapt_pkg::CTRL_RST;
      end else if (wr_slot[i] && reg_sel == sapt_pkg::REG_CTRL) begin
        ctrl_ff[i] <= be_merge(ctrl_ff[i], avs_writedata, avs_byteenable) & ctrl_mask(i);
      end
    end

    // Prescaler cleared on control write while running
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        pre_ff[i] <= 8'h00;
      end else if (wr_slot[i] && reg_sel == sapt_pkg::REG_CTRL &&
                   ctrl_ff[i][sapt_pkg::BIT_RUN]) begin
        pre_ff[i] <= 8'h00;
      end else if (tick_w[i]) begin
        pre_ff[i] <= 8'h00;
      end else if (evt[i]) begin
        pre_ff[i] <= pre_ff[i] + 8'h01;
      end
    end

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        period_ff[i] <= sapt_pkg::PERIOD_RST;
      end else if (wr_slot[i] && reg_sel == sapt_pkg::REG_PERIOD) begin
        period_ff[i] <= be_merge(period_ff[i], avs_writedata, avs_byteenable);
      end
    end

    // Counting; a bus write to the count takes priority.
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        count_ff[i] <= sapt_pkg::COUNT_RST;
      end else if (wr_slot[i] && reg_sel == sapt_pkg::REG_COUNT) begin
        count_ff[i] <= be_merge(count_ff[i], avs_writedata, avs_byteenable);
      end else if (use_tick[i]) begin
        if (wide[i]) begin
          if (match32[PI]) count_ff[i] <= sapt_pkg::COUNT_RST;
          else if (!IS_ODD) count_ff[i] <= count_ff[i] + 16'h0001;
          else count_ff[i] <= count_ff[i] + {15'h0000, carry32[PI]};
        end else if (count_ff[i] == period_ff[i]) begin
          count_ff[i] <= sapt_pkg::COUNT_RST;
        end else begin
          count_ff[i] <= count_ff[i] + 16'h0001;
        end
      end
    end

    // Enable and priority; the flag is write-one-to-clear and a set wins.
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        flag_ff[i] <= 1'b0;
        ien_ff[i]  <= 1'b0;
        prio_ff[i] <= 3'h0;
      end else begin
        if (wr_slot[i] && reg_sel == sapt_pkg::REG_IRQ && avs_byteenable[0]) begin
          ien_ff[i]  <= avs_writedata[sapt_pkg::IRQ_EN];
          prio_ff[i] <= avs_writedata[sapt_pkg::IRQ_PRIO_LO +: sapt_pkg::PRIO_W];
        end
        flag_ff[i] <= set_flag[i] || (flag_ff[i] && !(wr_slot[i] &&
                      reg_sel == sapt_pkg::REG_IRQ && avs_byteenable[0] &&
                      avs_writedata[sapt_pkg::IRQ_FLAG]));
      end
    end
  end

  // Converter trigger only from pair A odd half, single-cycle pulse
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_req_ff     <= 5'h00;
      adc_trigger_ff <= 1'b0;
    end else begin
      irq_req_ff     <= flag_ff & ien_ff;
      adc_trigger_ff <= set_match[sapt_pkg::T_A_ODD];
    end
  end

  assign avs_readdata    = readdata_ff;
  assign avs_waitrequest = waitreq_ff;
  assign irq_req         = irq_req_ff;
  assign irq_priority    = {prio_ff[4], prio_ff[3], prio_ff[2], prio_ff[1], prio_ff[0]};
  assign adc_trigger     = adc_trigger_ff;

  // Checks on the standalone timer and on pair A.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic cnt0_wr;
  assign cnt0_wr = wr_slot[0] && reg_sel == sapt_pkg::REG_COUNT;

  run_stop_a: assert property (
    !ctrl_ff[0][sapt_pkg::BIT_RUN] && !cnt0_wr |=> $stable(count_ff[0]))
    else $error("stopped standalone timer changed its count");
  idle_halt_a: assert property (
    idle_mode && ctrl_ff[0][sapt_pkg::BIT_IDLE] |-> !evt[0] && !tick_w[0])
    else $error("timer counted while idle stop was active");
  gate_low_a: assert property (
    ctrl_ff[0][sapt_pkg::BIT_GATE] && !ctrl_ff[0][sapt_pkg::BIT_CS] && !pin_s2_ff[0]
    |-> !evt[0])
    else $error("gated timer counted with gate low");
  ps_one_a: assert property (
    running[0] && !ctrl_ff[0][sapt_pkg::BIT_CS] && !ctrl_ff[0][sapt_pkg::BIT_GATE] &&
    ctrl_ff[0][sapt_pkg::BIT_PS_HI:sapt_pkg::BIT_PS_LO] == sapt_pkg::PS_1 |-> tick_w[0])
    else $error("1:1 prescale did not count every cycle");
  ps_eight_a: assert property (
    tick_w[0] && ctrl_ff[0][sapt_pkg::BIT_PS_HI:sapt_pkg::BIT_PS_LO] == sapt_pkg::PS_8
    |-> pre_ff[0] >= sapt_pkg::PRE_LAST_8)
    else $error("1:8 prescale ticked early");
  ctrl_zero_a: assert property (
    (ctrl_ff[0] & ~sapt_pkg::MASK_SOLO) == 16'h0000 &&
    (ctrl_ff[2] & ~sapt_pkg::MASK_ODD) == 16'h0000)
    else $error("unimplemented control bit set");
  pre_clear_a: assert property (
    wr_slot[0] && reg_sel == sapt_pkg::REG_CTRL && ctrl_ff[0][sapt_pkg::BIT_RUN]
    |=> pre_ff[0] == 8'h00)
    else $error("prescaler kept running across control write");
  period_wrap_a: assert property (
    use_tick[0] && count_ff[0] == period_ff[0] && !cnt0_wr
    |=> count_ff[0] == sapt_pkg::COUNT_RST ##0 flag_ff[0])
    else $error("period match did not wrap and flag");
  wide_flag_a: assert property (
    wide[2] && set_match[2] |=> flag_ff[2] ##0 adc_trigger_ff)
    else $error("wide match not reported on odd flag and trigger");
  wide_carry_a: assert property (
    wide[2] && use_tick[2] && !match32[0] && carry32[0] && !wr_slot[2] && !wr_slot[1]
    |=> count_ff[2] == $past(count_ff[2]) + 16'h0001 && count_ff[1] == 16'h0000)
    else $error("low word overflow did not carry into high word");
  trig_src_a: assert property (
    adc_trigger_ff |-> $past(set_match[sapt_pkg::T_A_ODD]))
    else $error("converter trigger without pair A match");

  wrap_c: cover property (use_tick[0] && count_ff[0] == period_ff[0]);
  wide_c: cover property (wide[2] && set_match[2]);
  gate_c: cover property (gfall[0]);
  ps_c:   cover property (tick_w[0] &&
    ctrl_ff[0][sapt_pkg::BIT_PS_HI:sapt_pkg::BIT_PS_LO] == sapt_pkg::PS_64);

endmodule : sapt_top

// ==== tb/sapt_ext_src.sv ====
// Model of the external clock and gate sources wired to the timer pins.
`timescale 1ns/100ps
module sapt_ext_src (
  input  wire logic       core_clk,
  output logic      [4:0] ext_pin
);
  initial ext_pin = 5'h00;

  // routed pin pulses.
  // Pins rest low between bursts, and each level lasts hold cycles; with hold of at
  // least two cycles, no edge can slip past the block's two-flop synchroniser.
  task automatic pulses(input int idx, input int n, input int hold);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge core_clk);
      ext_pin[idx] <= ~ext_pin[idx];
      repeat (hold - 1) @(posedge core_clk);
    end
  endtask : pulses
endmodule : sapt_ext_src

// ==== tb/tb.sv ====
// Self-checking bench for the standalone and paired timer block.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module tb;
  logic        core_clk       = 1'b0;
  logic        rst            = 1'b1;
  logic [7:0]  avs_address    = 8'h00;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        idle_mode      = 1'b0;
  logic [4:0]  ext_pin;
  logic [4:0]  irq_req;
  logic [14:0] irq_priority;
  logic        adc_trigger;
  logic [15:0] rd;
  int          n_fail         = 0;
  int          comparisons    = 0;
  int          cycles         = 0;
  int          n_trig         = 0;

  always #10 core_clk = ~core_clk;

  sapt_top #(.NUM_TIMERS(sapt_pkg::NUM_TIMERS)) i_sapt_top (
    .core_clk                 (core_clk),
    .rst                      (rst),
    .avs_address              (avs_address),
    .avs_read                 (avs_read),
    .avs_write                (avs_write),
    .avs_writedata            (avs_writedata),
    .avs_byteenable           (avs_byteenable),
    .avs_readdata             (avs_readdata),
    .avs_waitrequest          (avs_waitrequest),
    .idle_mode                (idle_mode),
    .standalone_ext_clock_pin (ext_pin[0]),
    .pair_ext_clock_pin       (ext_pin[4:1]),
    .irq_req                  (irq_req),
    .irq_priority             (irq_priority),
    .adc_trigger              (adc_trigger)
  );

  sapt_ext_src i_sapt_ext_src (
    .core_clk (core_clk),
    .ext_pin  (ext_pin)
  );

  task automatic report_and_stop();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // The whole run needs under three thousand cycles; the ceiling leaves ample margin.
  always @(posedge core_clk) begin
    cycles++;
    if (adc_trigger === 1'b1) n_trig <= n_trig + 1;
    if (cycles == 12000) begin
      n_fail++;
      report_and_stop();
    end
  end

  function automatic logic [7:0] ra(input int s, input logic [1:0] r);
    return {1'b0, 3'(s), r, 2'b00};
  endfunction : ra

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge core_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[15:0];
    avs_read <= 1'b0;
  endtask : rdr

  task automatic t_regs();
    rdr(ra(0, sapt_pkg::REG_PERIOD));
    `CHK("period_rst", sapt_pkg::PERIOD_RST, rd)
    rdr(8'h80);
    `CHK("unmapped", 16'h0000, rd)
    wr(ra(0, sapt_pkg::REG_CTRL), 16'h7fff);
    rdr(ra(0, sapt_pkg::REG_CTRL));
    `CHK("ctrl_solo", 16'h2076, rd)
    wr(ra(1, sapt_pkg::REG_CTRL), 16'h7fff);
    rdr(ra(1, sapt_pkg::REG_CTRL));
    `CHK("ctrl_even", 16'h207a, rd)
    wr(ra(2, sapt_pkg::REG_CTRL), 16'h7fff);
    rdr(ra(2, sapt_pkg::REG_CTRL));
    `CHK("ctrl_odd", 16'h2072, rd)
    for (int s = 0; s < 3; s++) wr(ra(s, sapt_pkg::REG_CTRL), 16'h0000);
  endtask : t_regs

  task automatic t_prescale();
    int          e;
    logic [15:0] c0;
    for (int ps = 0; ps < 4; ps++) begin
      wr(ra(0, sapt_pkg::REG_COUNT), 16'h0000);
      wr(ra(0, sapt_pkg::REG_CTRL), 16'h8000 | (16'(ps) << 4));
      repeat (510) @(posedge core_clk);
      wr(ra(0, sapt_pkg::REG_CTRL), 16'(ps) << 4);
      e = 513 >> ((ps == 3) ? 8 : 3 * ps);
      rdr(ra(0, sapt_pkg::REG_COUNT));
      c0 = rd;
      `CHK("ps_count", 1'b1, (rd >= 16'(e - 2) && rd <= 16'(e + 2)))
      repeat (20) @(posedge core_clk);
      rdr(ra(0, sapt_pkg::REG_COUNT));
      `CHK("stopped", c0, rd)
    end
  endtask : t_prescale

  task automatic t_match();
    wr(ra(0, sapt_pkg::REG_COUNT), 16'h0000);
    wr(ra(0, sapt_pkg::REG_PERIOD), 16'h0004);
    wr(ra(0, sapt_pkg::REG_IRQ), 16'h0052);
    wr(ra(0, sapt_pkg::REG_CTRL), 16'h8000);
    for (int i = 0; i < 40 && irq_req[0] !== 1'b1; i++) @(posedge core_clk);
    `CHK("irq_solo", 1'b1, irq_req[0])
    `CHK("prio_solo", 3'h5, irq_priority[2:0])
    repeat (12) @(posedge core_clk);
    wr(ra(0, sapt_pkg::REG_CTRL), 16'h0000);
    rdr(ra(0, sapt_pkg::REG_COUNT));
    `CHK("wrapped", 1'b1, rd <= 16'h0004)
    wr(ra(0, sapt_pkg::REG_IRQ), 16'h0053);
    rdr(ra(0, sapt_pkg::REG_IRQ));
    `CHK("flag_clr", 16'h0052, rd & 16'h0073)
  endtask : t_match

  task automatic t_idle();
    wr(ra(0, sapt_pkg::REG_COUNT), 16'h0000);
    // The short period left by the match scenario would wrap the count here.
    wr(ra(0, sapt_pkg::REG_PERIOD), 16'hffff);
    idle_mode <= 1'b1;
    wr(ra(0, sapt_pkg::REG_CTRL), 16'ha000);
    repeat (30) @(posedge core_clk);
    rdr(ra(0, sapt_pkg::REG_COUNT));
    `CHK("idle_held", 16'h0000, rd)
    wr(ra(0, sapt_pkg::REG_CTRL), 16'h8000);
    repeat (30) @(posedge core_clk);
    wr(ra(0, sapt_pkg::REG_CTRL), 16'h0000);
    rdr(ra(0, sapt_pkg::REG_COUNT));
    `CHK("idle_runs", 1'b1, rd >= 16'd30 && rd <= 16'd38)
    idle_mode <= 1'b0;
  endtask : t_idle

  task automatic t_gate();
    wr(ra(0, sapt_pkg::REG_COUNT), 16'h0000);
    wr(ra(0, sapt_pkg::REG_IRQ), 16'h0001);
    wr(ra(0, sapt_pkg::REG_CTRL), 16'h8040);
    repeat (20) @(posedge core_clk);
    rdr(ra(0, sapt_pkg::REG_COUNT));
    `CHK("gate_low", 16'h0000, rd)
    i_sapt_ext_src.pulses(0, 1, 40);
    repeat (10) @(posedge core_clk);
    rdr(ra(0, sapt_pkg::REG_COUNT));
    `CHK("gate_high", 1'b1, rd >= 16'd36 && rd <= 16'd44)
    rdr(ra(0, sapt_pkg::REG_IRQ));
    `CHK("gate_fall", 1'b1, rd[0])
    wr(ra(0, sapt_pkg::REG_CTRL), 16'h8046);
    wr(ra(0, sapt_pkg::REG_COUNT), 16'h0000);
    i_sapt_ext_src.pulses(0, 10, 3);
    repeat (10) @(posedge core_clk);
    wr(ra(0, sapt_pkg::REG_CTRL), 16'h0000);
    rdr(ra(0, sapt_pkg::REG_COUNT));
    `CHK("ext_edges", 16'h000a, rd)
  endtask : t_gate

  task automatic t_wide();
    int t0;
    wr(ra(1, sapt_pkg::REG_IRQ), 16'h0003);
    wr(ra(2, sapt_pkg::REG_IRQ), 16'h0003);
    wr(ra(2, sapt_pkg::REG_CTRL), 16'h0030);
    wr(ra(1, sapt_pkg::REG_PERIOD), 16'hfff8);
    wr(ra(2, sapt_pkg::REG_PERIOD), 16'h0001);
    wr(ra(1, sapt_pkg::REG_COUNT), 16'hfff0);
    wr(ra(2, sapt_pkg::REG_COUNT), 16'h0000);
    t0 = n_trig;
    wr(ra(1, sapt_pkg::REG_CTRL), 16'h8008);
    repeat (40) @(posedge core_clk);
    wr(ra(1, sapt_pkg::REG_CTRL), 16'h0008);
    rdr(ra(2, sapt_pkg::REG_COUNT));
    `CHK("wide_carry", 16'h0001, rd)
    `CHK("no_early", t0, n_trig)
    wr(ra(1, sapt_pkg::REG_COUNT), 16'hfff0);
    wr(ra(1, sapt_pkg::REG_CTRL), 16'h8008);
    for (int i = 0; i < 40 && n_trig == t0; i++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    `CHK("wide_trig", t0 + 1, n_trig)
    `CHK("odd_irq", 1'b1, irq_req[2])
    `CHK("even_irq", 1'b0, irq_req[1])
    wr(ra(1, sapt_pkg::REG_CTRL), 16'h0000);
  endtask : t_wide

  task automatic t_pairb();
    int t0;
    t0 = n_trig;
    wr(ra(3, sapt_pkg::REG_PERIOD), 16'h0003);
    wr(ra(3, sapt_pkg::REG_COUNT), 16'h0000);
    wr(ra(3, sapt_pkg::REG_CTRL), 16'h8002);
    i_sapt_ext_src.pulses(3, 6, 3);
    repeat (8) @(posedge core_clk);
    wr(ra(3, sapt_pkg::REG_CTRL), 16'h0000);
    rdr(ra(3, sapt_pkg::REG_COUNT));
    `CHK("pair_count", 16'h0002, rd)
    rdr(ra(3, sapt_pkg::REG_IRQ));
    `CHK("pair_flag", 1'b1, rd[0])
    `CHK("pair_no_trig", t0, n_trig)
  endtask : t_pairb

  // run bit is written last in every setup except the external-edge step of t_gate, which clears the count after it.
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_prescale();
    t_match();
    t_idle();
    t_gate();
    t_wide();
    t_pairb();
    report_and_stop();
  end
endmodule : tb
